// ==== src/mmd_host_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mmd_defs.svh"

module mmd_host_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic bus_mode_strap_0,
  input wire logic bus_mode_strap_1,
  input wire logic bus_mode_strap_2,
  input wire logic chip_select_n,
  input wire logic hard_reset_n,
  input wire logic data_cmd_sel,
  input wire logic read_write_sel,
  input wire logic enable_strobe,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic [7:0] host_data_oe_n,
  input wire logic [7:0] read_byte,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic wr_is_data,
  output logic rd_req,
  output logic init_active,
  output var mmd_pkg::mmd_mode_type bus_mode
);
  import mmd_pkg::*;

  // ******************************************************************
  // Pin synchronisers.
  // ******************************************************************
  logic [`MMD_PIN_W-1:0] pin_meta;
  logic [`MMD_PIN_W-1:0] pin_sync;
  logic [`MMD_PIN_W-1:0] pin_prev;
  wire logic [`MMD_PIN_W-1:0] pin_raw;
  wire logic cs_act;
  wire logic init;
  wire logic dc_s;
  wire logic rw_s;
  wire logic rw_p;
  wire logic en_s;
  wire logic en_p;
  wire logic [2:0] straps;
  wire logic [7:0] data_s;
  wire logic [7:0] data_p;

  assign pin_raw = {host_data_in, bus_mode_strap_2, bus_mode_strap_1,
                    bus_mode_strap_0, enable_strobe, read_write_sel,
                    data_cmd_sel, hard_reset_n, chip_select_n};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= `MMD_PIN_RST;
      pin_sync <= `MMD_PIN_RST;
      pin_prev <= `MMD_PIN_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign cs_act = ~pin_sync[`MMD_PIN_CS];
  assign init = sys_rst | ~pin_sync[`MMD_PIN_RES];
  assign dc_s = pin_sync[`MMD_PIN_DC];
  assign rw_s = pin_sync[`MMD_PIN_RW];
  assign rw_p = pin_prev[`MMD_PIN_RW];
  assign en_s = pin_sync[`MMD_PIN_EN];
  assign en_p = pin_prev[`MMD_PIN_EN];
  assign straps = pin_sync[`MMD_PIN_STRAP +: 3];
  assign data_s = pin_sync[`MMD_PIN_DATA +: 8];
  assign data_p = pin_prev[`MMD_PIN_DATA +: 8];

  // ******************************************************************
  // Bus mode from the straps.
  // ******************************************************************
  wire mmd_mode_type next_mode;

  // Unlisted strap codes park the port so it answers no traffic at all.
  assign next_mode = (straps == `MMD_STRAP_SPI3) ? MMD_SPI3 :
                     (straps == `MMD_STRAP_SPI4) ? MMD_SPI4 :
                     (straps == `MMD_STRAP_P6800) ? MMD_P6800 :
                     (straps == `MMD_STRAP_P8080) ? MMD_P8080 :
                     (straps == `MMD_STRAP_I2C) ? MMD_I2C :
                     MMD_UNSUP;

  always_ff @(posedge ref_clk) begin
    if (init) begin
      bus_mode <= MMD_UNSUP;
    end else begin
      bus_mode <= next_mode;
    end
  end

  // ******************************************************************
  // Parallel strobes.
  // ******************************************************************
  logic reading;
  wire logic is_6800;
  wire logic is_8080;
  wire logic e_start;
  wire logic par_wr;
  wire logic par_rd;
  wire logic rd_hold;
  wire logic next_reading;

  assign is_6800 = (bus_mode == MMD_P6800);
  assign is_8080 = (bus_mode == MMD_P8080);
  assign e_start = is_6800 & cs_act & en_s & ~en_p;
  // Read/write select steers the 6800 cycle; the 8080 strobes start on
  // their own falling edges, each only while selected.
  assign par_wr = (e_start & ~rw_s) |
                  (is_8080 & cs_act & ~rw_s & rw_p);
  assign par_rd = (e_start & rw_s) |
                  (is_8080 & cs_act & ~en_s & en_p);
  assign rd_hold = cs_act & (is_6800 ? en_s : (is_8080 & ~en_s));
  assign next_reading = ~init & (par_rd | (reading & rd_hold));

  // ******************************************************************
  // Serial byte hand-over from the shift clock domain.
  // ******************************************************************
  mmd_ser_if ser ();
  logic tog_meta;
  logic tog_sync;
  logic tog_prev;
  wire logic spi_mode;
  wire logic spi_wr;

  // The shift clock is bus bit 0 on the board; bit 1 carries the data.
  mmd_serial_shifter u_shift (
    .serial_clk(serial_clk),
    .sys_rst(sys_rst),
    .chip_select_n(chip_select_n),
    .serial_data_in(host_data_in[`MMD_BIT_SDI]),
    .data_cmd_sel(data_cmd_sel),
    .ser(ser.link)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      ser.three_wire <= 1'b0;
    end else begin
      tog_meta <= ser.byte_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      ser.three_wire <= (bus_mode == MMD_SPI3);
    end
  end

  assign spi_mode = (bus_mode == MMD_SPI3) | (bus_mode == MMD_SPI4);
  // Toggle edges always reach the core so a mode change never leaves a
  // stale byte waiting; outside SPI modes they are simply dropped.
  assign spi_wr = spi_mode & (tog_sync ^ tog_prev);

  // ******************************************************************
  // I2C write slave.
  // ******************************************************************
  mmd_i2c_type i2c_state;
  mmd_i2c_type next_i2c_state;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_shift;
  logic i2c_is_data;
  logic ack_pend;
  logic ack_on;
  wire logic is_i2c;
  wire logic scl;
  wire logic scl_p;
  wire logic sda;
  wire logic sda_p;
  wire logic scl_rise;
  wire logic scl_fall;
  wire logic i2c_start;
  wire logic i2c_stop;
  wire logic bit_take;
  wire logic byte_end;
  wire logic addr_hit;
  wire logic i2c_wr;
  wire logic next_ack_on;
  wire logic [7:0] i2c_byte;

  assign is_i2c = (bus_mode == MMD_I2C) & cs_act;
  assign scl = data_s[`MMD_BIT_SCL];
  assign scl_p = data_p[`MMD_BIT_SCL];
  assign sda = data_s[`MMD_BIT_SDI];
  assign sda_p = data_p[`MMD_BIT_SDI];
  assign scl_rise = scl & ~scl_p;
  assign scl_fall = ~scl & scl_p;
  assign i2c_start = is_i2c & scl & scl_p & ~sda & sda_p;
  assign i2c_stop = is_i2c & scl & scl_p & sda & ~sda_p;
  assign bit_take = is_i2c & scl_rise & ~ack_on &
                    (i2c_state != MMD_I2C_IDLE) &
                    (i2c_state != MMD_I2C_SKIP);
  assign i2c_byte = {i2c_shift[6:0], sda};
  assign byte_end = bit_take & (i2c_cnt == `MMD_I2C_LAST);
  // The data/command pin supplies the lowest address bit; only writes
  // are answered.
  assign addr_hit = (i2c_byte[7:1] == {`MMD_I2C_ADDR_HI, dc_s}) &
                    ~i2c_byte[0];
  assign i2c_wr = byte_end & (i2c_state == MMD_I2C_DATA);
  assign next_ack_on = ~init & is_i2c & ~i2c_stop &
                       (scl_fall ? ack_pend : ack_on);

  always_comb begin
    next_i2c_state = i2c_state;
    if (i2c_start) begin
      next_i2c_state = MMD_I2C_ADDR;
    end else if (i2c_stop || !is_i2c) begin
      next_i2c_state = MMD_I2C_IDLE;
    end else if (byte_end) begin
      case (i2c_state)
        MMD_I2C_ADDR: begin
          next_i2c_state = addr_hit ? MMD_I2C_CTRL : MMD_I2C_SKIP;
        end
        MMD_I2C_CTRL: begin
          next_i2c_state = MMD_I2C_DATA;
        end
        MMD_I2C_DATA: begin
          next_i2c_state = MMD_I2C_DATA;
        end
        default: begin
          next_i2c_state = MMD_I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (init) begin
      i2c_state <= MMD_I2C_IDLE;
      i2c_cnt <= 4'h0;
      i2c_shift <= `MMD_BYTE_RST;
      i2c_is_data <= 1'b0;
      ack_pend <= 1'b0;
    end else begin
      i2c_state <= next_i2c_state;
      if (i2c_start || byte_end) begin
        i2c_cnt <= 4'h0;
      end else if (bit_take) begin
        i2c_cnt <= i2c_cnt + 4'h1;
      end
      if (bit_take) begin
        i2c_shift <= i2c_byte;
      end
      if (byte_end && i2c_state == MMD_I2C_CTRL) begin
        i2c_is_data <= i2c_byte[`MMD_I2C_CTRL_DC];
      end
      if (byte_end && (i2c_state != MMD_I2C_ADDR || addr_hit)) begin
        ack_pend <= 1'b1;
      end else if (scl_fall || !is_i2c) begin
        ack_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    ack_on <= next_ack_on;
  end

  // ******************************************************************
  // Output registers.
  // ******************************************************************
  wire logic next_wr_valid;
  wire logic [7:0] next_wr_byte;
  wire logic next_wr_dc;
  wire logic [7:0] next_oe_n;

  assign next_wr_valid = par_wr | spi_wr | i2c_wr;
  assign next_wr_byte = par_wr ? data_s :
                        spi_wr ? ser.byte_data : i2c_byte;
  assign next_wr_dc = par_wr ? dc_s :
                      spi_wr ? ser.byte_dc :
                      i2c_is_data;
  // The acknowledge pulls only the output lane low; the input lane is
  // tied to it on the board and must stay undriven here.
  assign next_oe_n = next_reading ? `MMD_OE_ALL :
                     next_ack_on ?
                     (`MMD_OE_OFF ^ (`MMD_LANE0 << `MMD_BIT_SDO)) :
                     `MMD_OE_OFF;

  always_ff @(posedge ref_clk) begin
    if (init) begin
      wr_valid <= 1'b0;
      wr_byte <= `MMD_BYTE_RST;
      wr_is_data <= 1'b0;
      rd_req <= 1'b0;
      reading <= 1'b0;
      host_data_oe_n <= `MMD_OE_OFF;
      host_data_out <= `MMD_BYTE_RST;
      init_active <= 1'b1;
    end else begin
      wr_valid <= next_wr_valid;
      if (next_wr_valid) begin
        wr_byte <= next_wr_byte;
        wr_is_data <= next_wr_dc;
      end
      rd_req <= par_rd;
      reading <= next_reading;
      host_data_oe_n <= next_oe_n;
      host_data_out <= next_reading ? read_byte : `MMD_BYTE_RST;
      init_active <= 1'b0;
    end
  end

  // ******************************************************************
  // Checks.
  // ******************************************************************
  a_strap_spi_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!$past(init) && $past(straps) == `MMD_STRAP_SPI3) |->
    bus_mode == MMD_SPI3)
    else $error("Three-wire straps did not select three-wire SPI.");

  a_strap_par_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!$past(init) && $past(straps) == `MMD_STRAP_P8080) |->
    bus_mode == MMD_P8080)
    else $error("8080 straps did not select the 8080 bus.");

  a_cs_gates_par: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_valid || rd_req) && ($past(is_6800) || $past(is_8080)) |->
    $past(cs_act))
    else $error("Parallel transfer taken while deselected.");

  a_init_quiets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(init) |-> (!wr_valid && !rd_req && init_active &&
    host_data_oe_n == `MMD_OE_OFF))
    else $error("Port not quiet during hard reset.");

  a_par_dc_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_valid && ($past(is_6800) || $past(is_8080))) |->
    (wr_is_data == $past(dc_s) && wr_byte == $past(data_s)))
    else $error("Parallel byte routed against data/command select.");

  a_e_starts_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_valid && $past(is_6800)) |->
    ($past(en_s) && !$past(en_p) && !$past(rw_s)))
    else $error("6800 write without an enable rise and write direction.");

  a_wr_strobe_8080: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_valid && $past(is_8080)) |->
    (!$past(rw_s) && $past(rw_p)))
    else $error("8080 write not started by a write strobe fall.");

  a_read_drives_bus: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_req |-> (host_data_oe_n == `MMD_OE_ALL &&
    host_data_out == $past(read_byte)))
    else $error("Read started without driving the data bus.");

  a_i2c_flag_used: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_valid && $past(bus_mode) == MMD_I2C) |->
    wr_is_data == $past(i2c_is_data))
    else $error("I2C byte classified by the data/command pin.");

  a_unsup_is_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(bus_mode) == MMD_UNSUP |-> (!wr_valid && !rd_req))
    else $error("Traffic accepted under an unsupported strap code.");

  a_ack_one_lane: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ack_on && !reading) |-> (host_data_oe_n[`MMD_BIT_SDO] == 1'b0 &&
    host_data_oe_n[`MMD_BIT_SDI] == 1'b1))
    else $error("Acknowledge not driven on the output lane alone.");

endmodule

`default_nettype wire

// ==== src/mmd_defs.svh ====
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// Overview of operation
// - Straps 0,1,2 reading 1,0,0 pick 3-wire SPI and 0,0,0 pick 4-wire SPI.
// - Straps 0,1,2 reading 0,0,1 pick the 6800 bus, 0,1,1 the 8080 bus.
// - Host traffic is taken only while the active-low chip select is low.
// - A low hard reset input resets the mode, I2C and output registers; the serial shifter and synchronisers keep their state.
// - A parallel byte written with data/command high is display data.
// - A parallel byte written with data/command low goes to the command path.
// - A 4-wire serial byte is data when data/command is high, command when low; a 3-wire byte takes its leading bit.
// - In I2C mode the data/command pin is the low slave address bit.
// - In 6800 mode read/write high asks for a read and low for a write.
// - In 8080 mode a write starts when the write strobe falls with select.
// - In 8080 mode a read starts when the read strobe falls with select.
// - The parallel data lines are input on writes and driven on reads.
// - In I2C mode bit 2 drives data out, bit 1 reads data, bit 0 is clock.

// ********************************************************************
// Strap codes, read as {strap 2, strap 1, strap 0}.
// ********************************************************************
`define MMD_STRAP_SPI3 3'h1
`define MMD_STRAP_SPI4 3'h0
`define MMD_STRAP_P6800 3'h4
`define MMD_STRAP_P8080 3'h6
`define MMD_STRAP_I2C 3'h2

// ********************************************************************
// Pin vector layout and lanes.
// ********************************************************************
`define MMD_PIN_W 16
`define MMD_PIN_CS 0
`define MMD_PIN_RES 1
`define MMD_PIN_DC 2
`define MMD_PIN_RW 3
`define MMD_PIN_EN 4
`define MMD_PIN_STRAP 5
`define MMD_PIN_DATA 8
`define MMD_BIT_SCL 0
`define MMD_BIT_SDI 1
`define MMD_BIT_SDO 2

// ********************************************************************
// Reset values, I2C addressing and bit counts.
// ********************************************************************
`define MMD_PIN_RST 16'h0001
`define MMD_OE_OFF 8'hFF
`define MMD_OE_ALL 8'h00
`define MMD_LANE0 8'h01
`define MMD_BYTE_RST 8'h00
`define MMD_I2C_ADDR_HI 6'h14
`define MMD_I2C_CTRL_DC 6
`define MMD_I2C_LAST 4'h7
`define MMD_SPI4_LAST 4'h7
`define MMD_SPI3_LAST 4'h8

`endif

// ==== src/mmd_pkg.sv ====
package mmd_pkg;

  typedef enum logic [2:0] {
    MMD_SPI3, MMD_SPI4, MMD_P6800, MMD_P8080, MMD_I2C, MMD_UNSUP
  } mmd_mode_type;

  typedef enum logic [2:0] {
    MMD_I2C_IDLE, MMD_I2C_ADDR, MMD_I2C_CTRL, MMD_I2C_DATA, MMD_I2C_SKIP
  } mmd_i2c_type;

endpackage

// ==== src/mmd_ser_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface mmd_ser_if;
  logic [7:0] byte_data;
  logic byte_dc;
  logic byte_toggle;
  logic three_wire;
  modport link (output byte_data, output byte_dc, output byte_toggle,
                input three_wire);
  modport core (input byte_data, input byte_dc, input byte_toggle,
                output three_wire);
endinterface

`default_nettype wire

// ==== src/mmd_serial_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mmd_defs.svh"

module mmd_serial_shifter (
  input wire logic serial_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic data_cmd_sel,
  mmd_ser_if.link ser
);
  import mmd_pkg::*;

  logic [3:0] bit_cnt;
  logic [6:0] shift;
  logic dc_first;
  logic three_meta;
  logic three_s;
  wire logic frame_clr;
  wire logic last_bit;
  wire logic [7:0] full_byte;

  // Deselect clears the bit count without needing a clock edge, since the
  // host may stop the shift clock as soon as a frame ends.
  assign frame_clr = chip_select_n | sys_rst;
  assign last_bit = three_s ? (bit_cnt == `MMD_SPI3_LAST)
                            : (bit_cnt == `MMD_SPI4_LAST);
  assign full_byte = {shift, serial_data_in};

  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      three_meta <= 1'b0;
      three_s <= 1'b0;
    end else begin
      three_meta <= ser.three_wire;
      three_s <= three_meta;
    end
  end

  always_ff @(posedge serial_clk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt <= 4'h0;
    end else if (last_bit) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge serial_clk) begin
    shift <= full_byte[6:0];
    if (three_s && bit_cnt == 4'h0) begin
      dc_first <= serial_data_in;
    end
  end

  // Data and flag settle together with the toggle and then hold for at
  // least seven more shift clocks while the core domain picks them up.
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser.byte_data <= `MMD_BYTE_RST;
      ser.byte_dc <= 1'b0;
      ser.byte_toggle <= 1'b0;
    end else if (!chip_select_n && last_bit) begin
      ser.byte_data <= full_byte;
      ser.byte_dc <= three_s ? dc_first : data_cmd_sel;
      ser.byte_toggle <= ~ser.byte_toggle;
    end
  end

  a_four_wire_dc: assert property (@(posedge serial_clk)
    disable iff (chip_select_n || sys_rst)
    (last_bit && !three_s) |=> ser.byte_dc == $past(data_cmd_sel))
    else $error("Four-wire byte took the wrong data/command flag.");

  a_three_wire_dc: assert property (@(posedge serial_clk)
    disable iff (chip_select_n || sys_rst)
    (last_bit && three_s) |=> ser.byte_dc == $past(dc_first))
    else $error("Three-wire byte lost its leading flag bit.");

endmodule

`default_nettype wire

// ==== verif/mmd_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host bus master: parallel strobes and serial frames.
// ****************************************************************
module mmd_host_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic dc,
  output logic rw,
  output logic en,
  output logic [7:0] bus,
  input wire logic ack_lane
);
  initial begin
    cs_n = 1'b1;
    dc = 1'b0;
    rw = 1'b0;
    en = 1'b0;
    bus = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Strobes are parked inactive before select falls, so no edge is seen.
  task automatic par(input logic m80, input logic rd, input logic sel,
                     input logic dv, input logic [7:0] v);
    tick(1);
    dc = dv;
    bus = rd ? ~bus : v;
    if (m80) begin
      rw = 1'b1;
      en = 1'b1;
    end else begin
      rw = rd;
    end
    tick(2);
    cs_n = ~sel;
    tick(2);
    if (m80 && rd) en = 1'b0;
    else if (m80) rw = 1'b0;
    else en = 1'b1;
    tick(8);
    if (m80) begin
      rw = 1'b1;
      en = 1'b1;
    end else begin
      en = 1'b0;
    end
    tick(3);
    cs_n = 1'b1;
    bus = ~bus;
  endtask

  // The shift clock on lane 0 rests low outside frames.
  task automatic spi(input logic three, input logic dv, input logic [7:0] v,
                     input int nbits);
    logic [8:0] s;
    int top;
    s = {dv, v};
    top = three ? 8 : 7;
    tick(1);
    bus = 8'h00;
    dc = dv;
    // The port learns the frame length on shift clock edges only, so two
    // deselected edges carry a strap change across before the frame.
    repeat (2) begin
      #8 bus[0] = 1'b1;
      #8 bus[0] = 1'b0;
    end
    #40;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      bus[1] = s[top-i];
      #16;
      bus[0] = 1'b1;
      #16;
      bus[0] = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    bus[7:1] = ~bus[7:1];
    tick(8);
  endtask

  // Address, control and data byte in one write frame. Lane 2 rests high
  // as if pulled up; an acknowledge shows as a low on it.
  task automatic i2c(input logic dv, input logic [7:0] a,
                     input logic [7:0] c, input logic [7:0] v,
                     output logic [2:0] acks);
    logic [23:0] s;
    s = {a, c, v};
    tick(1);
    dc = dv;
    bus = 8'h07;
    tick(4);
    cs_n = 1'b0;
    tick(4);
    bus[1] = 1'b0;
    tick(4);
    bus[0] = 1'b0;
    for (int n = 0; n < 27; n++) begin
      if (n % 9 == 8) begin
        bus[1] = 1'b1;
      end else begin
        bus[1] = s[23];
        s = s << 1;
      end
      tick(4);
      bus[0] = 1'b1;
      tick(4);
      if (n % 9 == 8) acks[n / 9] = ack_lane;
      bus[0] = 1'b0;
    end
    bus[1] = 1'b0;
    tick(4);
    bus[0] = 1'b1;
    tick(4);
    bus[1] = 1'b1;
    tick(4);
    cs_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== verif/mmd_host_port_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Self-checking bench with a queue model of accepted bytes.
// ****************************************************************
module mmd_host_port_bench;
  import mmd_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic hard_reset_n = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [7:0] read_byte = 8'h00;
  wire logic cs_n, dc, rw, en, wr_valid, wr_is_data, rd_req, init_active;
  wire logic [7:0] hbus, din, dout, oe_n, wr_byte;
  mmd_mode_type bus_mode;
  int n_errors = 0;
  int samples_checked = 0;
  int n_rd = 0;
  int rd_wait = 0;
  logic [8:0] exp_q[$];

  always #20 ref_clk = ~ref_clk;
  assign din = (oe_n & hbus) | (~oe_n & dout);

  mmd_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .dc(dc), .rw(rw),
    .en(en), .bus(hbus), .ack_lane(din[2]));

  mmd_host_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .serial_clk(din[0]), .bus_mode_strap_0(strap[0]),
    .bus_mode_strap_1(strap[1]), .bus_mode_strap_2(strap[2]),
    .chip_select_n(cs_n), .hard_reset_n(hard_reset_n),
    .data_cmd_sel(dc), .read_write_sel(rw), .enable_strobe(en),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
    .read_byte(read_byte), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .wr_is_data(wr_is_data), .rd_req(rd_req), .init_active(init_active),
    .bus_mode(bus_mode));

  task automatic fail(input string what);
    n_errors++;
    $display("wrong value at %0t: %s", $time, what);
  endtask

  task automatic check_val(input logic [8:0] got, input logic [8:0] exp,
                           input string what);
    samples_checked++;
    if (got !== exp) fail(what);
  endtask

  task automatic check_mode(input logic [2:0] s);
    mmd_mode_type m;
    case (s)
      3'h1: m = MMD_SPI3;
      3'h0: m = MMD_SPI4;
      3'h4: m = MMD_P6800;
      3'h6: m = MMD_P8080;
      3'h2: m = MMD_I2C;
      default: m = MMD_UNSUP;
    endcase
    strap = s;
    host.tick(6);
    samples_checked++;
    if (bus_mode !== m) fail("bus mode");
  endtask

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected write");
      else check_val({wr_is_data, wr_byte}, exp_q.pop_front(), "write");
    end
    if (rd_req === 1'b1) begin
      if (n_rd == 0) fail("unexpected read");
      else n_rd--;
      rd_wait = 4;
    end
    if (rd_wait == 1) begin
      check_val({1'b0, oe_n}, 9'h000, "read enable");
      check_val({1'b0, dout}, {1'b0, read_byte}, "read data");
    end
    if (rd_wait > 0) rd_wait--;
  end

  initial begin
    logic [7:0] v;
    logic d;
    logic rd;
    int nb;
    logic [7:0] ctl;
    logic [2:0] ack;
    void'($urandom(40967));
    // Reset must rise after time zero: the shift clock domain clears on
    // its edge and would otherwise start unknown.
    #1;
    sys_rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    host.tick(6);
    for (int c = 0; c < 8; c++) check_mode(c[2:0]);
    for (int k = 0; k < 2; k++) begin
      check_mode(k == 0 ? 3'h4 : 3'h6);
      for (int i = 0; i < 6; i++) begin
        v = $urandom;
        d = $urandom;
        rd = (i == 2 || i == 3);
        if (rd) begin
          read_byte = $urandom;
          n_rd++;
        end else if (i != 4) begin
          exp_q.push_back({d, v});
        end
        host.par(k[0], rd, i != 4, d, v);
      end
    end
    for (int k = 0; k < 2; k++) begin
      check_mode(k[2:0] ^ 3'h0);
      for (int i = 0; i < 5; i++) begin
        v = $urandom;
        d = $urandom;
        nb = (i == 1) ? 5 : 8 + k;
        if (nb > 5) exp_q.push_back({d, v});
        host.spi(k[0], d, v, nb);
      end
    end
    check_mode(3'h2);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      d = $urandom;
      ctl = $urandom;
      rd = (i == 1);
      if (!rd) exp_q.push_back({ctl[6], v});
      host.i2c(d, {6'h14, d ^ rd, 1'b0}, ctl, v, ack);
      check_val({6'h00, ack}, rd ? 9'h007 : 9'h000, "ack");
    end
    hard_reset_n = 1'b0;
    host.tick(4);
    check_val({1'b0, oe_n}, 9'h0ff, "reset enable");
    check_val({8'h00, init_active}, 9'h001, "init");
    hard_reset_n = 1'b1;
    host.tick(8);
    check_val({8'h00, init_active}, 9'h000, "init end");
    if (exp_q.size() != 0 || n_rd != 0) fail("missing transfers");
    conclude();
  end

  initial begin
    #200000;
    fail("timeout");
    conclude();
  end
endmodule

`default_nettype wire
